// ---- compact_timer.sv ----
// compact timer: pin control, buffered byte access, counter and comparators
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module compact_timer
#(
  parameter int CNT_W = 10
)
(
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // register port
  input  wire compact_timer_pkg::regReq_t req,
  output logic [7:0]                      rdData,
  // clock sources
  input  wire logic                       tbcTick,
  input  wire logic                       extClkPin,
  // shared pin functions
  input  wire logic [1:0]                 sharedOut,
  input  wire logic [1:0]                 sharedOe,
  // timer pins
  output logic [1:0]                      pinOut,
  output logic [1:0]                      pinOe,
  output compact_timer_pkg::pinSel_t      pinSel,
  // interrupt requests
  output logic                            irqA,
  output logic                            irqP
);
  import compact_timer_pkg::*;

  // ****************************************************************
  // parameter check
  // ****************************************************************
  if (CNT_W != 10)
  begin : gBadWidth
    $error("compact_timer supports a 10-bit counter only");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]       pinPri_r;
  logic [7:0]       pinSec_r;
  logic [7:0]       ctrl0_r;
  logic [7:0]       ctrl1_r;
  logic [7:0]       aux_r;
  logic [7:0]       holdBuf_r;
  logic [CNT_W-1:0] cmpA_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [5:0]       presc_r;
  logic             extPrev_r;
  logic             runPrev_r;
  logic             outLvl_r;
  logic [7:0]       rdData_r;
  logic             irqA_r;
  logic             irqP_r;
  logic [1:0]       pinOut_r;
  logic [1:0]       pinOe_r;

  logic             runOn;
  logic             runRise;
  logic             tick;
  logic             step;
  logic [CNT_W-1:0] incVal;
  logic             overflow;
  logic             matchP;
  logic             matchA;
  logic             clrOnP;
  logic [2:0]       period;
  logic [1:0]       ioSel;
  mode_t            modeNow;
  logic             pwmActive;
  logic [CNT_W-1:0] duty;
  logic             timerLvl;
  logic [1:0]       timerPin;

  function automatic logic isAcc(input regReq_t r, input logic [3:0] ofs);
    isAcc = (r.addr == ofs);
  endfunction

  function automatic mode_t decodeMode(input logic [1:0] code);
    unique case (code)
      MODE_CODE_CMP: decodeMode = MODE_CMP;
      MODE_CODE_PWM: decodeMode = MODE_PWM;
      default:       decodeMode = MODE_TMR;
    endcase
  endfunction

  assign runOn   = ctrl0_r[C0_RUN];
  assign runRise = runOn && !runPrev_r;
  assign period  = ctrl0_r[C0_PER_LSB +: 3];
  assign ioSel   = ctrl1_r[C1_IO_LSB +: 2];
  assign modeNow = decodeMode(ctrl1_r[C1_MODE_LSB +: 2]);

  // ****************************************************************
  // register writes
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pinPri_r <= PIN_PRI_RST;
      pinSec_r <= PIN_SEC_RST;
      ctrl0_r  <= CTRL_RST;
      ctrl1_r  <= CTRL_RST;
      aux_r    <= CTRL_RST;
    end
    else if (req.wr)
    begin
      if (isAcc(req, OFS_PIN_PRI))
        pinPri_r <= req.wdata & PIN_PRI_MASK;
      if (isAcc(req, OFS_PIN_SEC))
        pinSec_r <= req.wdata & PIN_SEC_MASK;
      if (isAcc(req, OFS_CTRL0))
        ctrl0_r <= req.wdata;
      if (isAcc(req, OFS_CTRL1))
        ctrl1_r <= req.wdata;
      if (isAcc(req, OFS_AUX))
        aux_r <= req.wdata & 8'h01;
    end
  end

  // ****************************************************************
  // holding buffer and compare A
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      holdBuf_r <= BYTE_ZERO;
    else if (req.wr && isAcc(req, OFS_CMPA_LO))
      holdBuf_r <= req.wdata;
    else if (req.rd && isAcc(req, OFS_CNT_HI))
      holdBuf_r <= cnt_r[7:0];
    else if (req.rd && isAcc(req, OFS_CMPA_HI))
      holdBuf_r <= cmpA_r[7:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cmpA_r <= '0;
    else if (req.wr && isAcc(req, OFS_CMPA_HI))
      cmpA_r <= {req.wdata[CNT_W-9:0], holdBuf_r};
  end

  // ****************************************************************
  // read data, one cycle after the strobe
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdData_r <= BYTE_ZERO;
    else if (req.rd)
    begin
      unique case (req.addr)
        OFS_PIN_PRI: rdData_r <= pinPri_r;
        OFS_PIN_SEC: rdData_r <= pinSec_r;
        OFS_CTRL0:   rdData_r <= ctrl0_r;
        OFS_CTRL1:   rdData_r <= ctrl1_r;
        OFS_AUX:     rdData_r <= aux_r;
        OFS_CNT_LO:  rdData_r <= holdBuf_r;
        OFS_CMPA_LO: rdData_r <= holdBuf_r;
        OFS_CNT_HI:  rdData_r <= 8'(cnt_r >> 8);
        OFS_CMPA_HI: rdData_r <= 8'(cmpA_r >> 8);
        default:     rdData_r <= BYTE_ZERO;
      endcase
    end
  end

  // ****************************************************************
  // counter clock selection
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      presc_r   <= 6'h00;
      extPrev_r <= 1'b0;
    end
    else
    begin
      presc_r   <= presc_r + 6'h01;
      extPrev_r <= extClkPin;
    end
  end

  always_comb
  begin
    unique case (ctrl0_r[C0_CLK_LSB +: 3])
      CLK_SYS4:  tick = (presc_r & PRE_MASK4) == PRE_MASK4;
      CLK_SYS:   tick = 1'b1;
      CLK_H16:   tick = (presc_r & PRE_MASK16) == PRE_MASK16;
      CLK_H64:   tick = (presc_r & PRE_MASK64) == PRE_MASK64;
      CLK_TBC:   tick = tbcTick;
      CLK_NONE:  tick = 1'b0;
      CLK_EXT_R: tick = extClkPin && !extPrev_r;
      CLK_EXT_F: tick = !extClkPin && extPrev_r;
    endcase
  end

  assign step = tick && runOn && !ctrl0_r[C0_PAUSE];

  // ****************************************************************
  // comparators and counter
  // ****************************************************************
  assign incVal   = cnt_r + 10'h001;
  assign overflow = step && (cnt_r == '1);
  assign matchP   = step && (period != PERIOD_FULL)
                    && (cnt_r[CNT_W-1 -: 3] != period)
                    && (incVal[CNT_W-1 -: 3] == period);
  assign matchA   = step && (incVal == cmpA_r);
  assign clrOnP   = (modeNow == MODE_PWM) ? !ctrl1_r[C1_DPX]
                                          : !ctrl1_r[C1_CCLR];

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (runRise)
      cnt_nxt = '0;
    else if (step)
    begin
      if ((clrOnP && matchP) || (!clrOnP && matchA))
        cnt_nxt = '0;
      else
        cnt_nxt = incVal;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r     <= '0;
      runPrev_r <= 1'b0;
      irqA_r    <= 1'b0;
      irqP_r    <= 1'b0;
    end
    else
    begin
      cnt_r     <= cnt_nxt;
      runPrev_r <= runOn;
      irqA_r    <= matchA && !runRise;
      irqP_r    <= (matchP || overflow) && !runRise;
    end
  end

  // ****************************************************************
  // output waveform per mode
  // ****************************************************************
  assign duty      = ctrl1_r[C1_DPX] ? {period, 7'h00} : cmpA_r;
  assign pwmActive = cnt_r < duty;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      outLvl_r <= 1'b0;
    else if (runRise)
      outLvl_r <= ctrl1_r[C1_OC];
    else if (matchA && (modeNow == MODE_CMP))
    begin
      unique case (ioSel)
        IO_NONE:   outLvl_r <= outLvl_r;
        IO_LOW:    outLvl_r <= 1'b0;
        IO_HIGH:   outLvl_r <= 1'b1;
        IO_TOGGLE: outLvl_r <= !outLvl_r;
      endcase
    end
  end

  always_comb
  begin
    unique case (modeNow)
      MODE_CMP: timerLvl = outLvl_r;
      MODE_PWM:
        if (ioSel == IO_HIGH)
          timerLvl = pwmActive ? ctrl1_r[C1_OC] : !ctrl1_r[C1_OC];
        else
          timerLvl = (ioSel == IO_LOW) ? ctrl1_r[C1_OC]
                                       : !ctrl1_r[C1_OC];
      MODE_TMR: timerLvl = 1'b0;
    endcase
  end

  assign timerPin[0] = timerLvl ^ ctrl1_r[C1_POL];
  assign timerPin[1] = timerPin[0] ^ aux_r[AUX_INV];

  // ****************************************************************
  // pin ownership
  // ****************************************************************
  for (genvar i = 0; i < 2; i++)
  begin : gPin
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        pinOut_r[i] <= 1'b0;
        pinOe_r[i]  <= 1'b0;
      end
      else if (pinPri_r[PRI_T0P0 + i])
      begin
        pinOut_r[i] <= timerPin[i];
        pinOe_r[i]  <= (modeNow != MODE_TMR);
      end
      else
      begin
        pinOut_r[i] <= sharedOut[i];
        pinOe_r[i]  <= sharedOe[i];
      end
    end
  end

  assign rdData           = rdData_r;
  assign irqA             = irqA_r;
  assign irqP             = irqP_r;
  assign pinOut           = pinOut_r;
  assign pinOe            = pinOe_r;
  assign pinSel.primary   = pinPri_r;
  assign pinSel.secondary = pinSec_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence loWriteA;
    req.wr && req.addr == OFS_CMPA_LO;
  endsequence
  sequence hiWriteA;
    req.wr && req.addr == OFS_CMPA_HI;
  endsequence

  lo_write_hold_a: assert property (loWriteA |=>
    cmpA_r == $past(cmpA_r) && holdBuf_r == $past(req.wdata))
    else $error("low byte write changed compare value");
  hi_write_latch_a: assert property (hiWriteA |=>
    cmpA_r == {$past(req.wdata[1:0]), $past(holdBuf_r)})
    else $error("high byte write did not latch buffer");
  write_pair_a: assert property (loWriteA ##1 hiWriteA |=>
    cmpA_r[7:0] == $past(req.wdata, 2))
    else $error("low then high write pair mismatched");
  hi_read_cap_a: assert property (req.rd && req.addr == OFS_CNT_HI |=>
    holdBuf_r == $past(cnt_r[7:0]) && rdData == {6'h00, $past(cnt_r[9:8])})
    else $error("high byte read did not capture low byte");
  lo_read_buf_a: assert property (req.rd && req.addr == OFS_CNT_LO |=>
    rdData == $past(holdBuf_r) && $stable(holdBuf_r))
    else $error("low byte read not from buffer");
  buf_quiet_a: assert property (!(req.wr && req.addr == OFS_CMPA_LO) &&
    !(req.rd && (req.addr == OFS_CNT_HI || req.addr == OFS_CMPA_HI))
    |=> $stable(holdBuf_r))
    else $error("holding buffer moved without high byte access");
  run_clear_a: assert property ($rose(runOn) |=> cnt_r == '0)
    else $error("run enable rise did not clear counter");
  period_clr_a: assert property (matchP && clrOnP && !runRise |=>
    cnt_r == '0 && irqP)
    else $error("period match did not clear counter");
  full_wrap_a: assert property (step && period == PERIOD_FULL &&
    cnt_r == 10'h3ff && !runRise |=> cnt_r == '0 && irqP)
    else $error("overflow did not wrap counter");
  match_a_irq_a: assert property (step && incVal == cmpA_r && !runRise
    |=> irqA)
    else $error("compare A match gave no request");
  irq_pulse_a: assert property (irqP |=> !irqP)
    else $error("period request longer than one cycle");
  pin_spare_a: assert property ((pinPri_r & ~PIN_PRI_MASK) == 8'h00 &&
    (pinSec_r & ~PIN_SEC_MASK) == 8'h00)
    else $error("unimplemented pin control bit set");
  pin_release_a: assert property (!pinPri_r[PRI_T0P0]
    |=> pinOut[0] == $past(sharedOut[0]) && pinOe[0] == $past(sharedOe[0]))
    else $error("released pin not on shared function");

endmodule
`default_nettype wire

// ---- compact_timer_pkg.sv ----
// constants, field layouts and carrier types for the compact timer
`default_nettype none
package compact_timer_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [3:0] OFS_PIN_PRI = 4'h0;
  localparam logic [3:0] OFS_PIN_SEC = 4'h1;
  localparam logic [3:0] OFS_CTRL0   = 4'h2;
  localparam logic [3:0] OFS_CTRL1   = 4'h3;
  localparam logic [3:0] OFS_CNT_LO  = 4'h4;
  localparam logic [3:0] OFS_CNT_HI  = 4'h5;
  localparam logic [3:0] OFS_CMPA_LO = 4'h6;
  localparam logic [3:0] OFS_CMPA_HI = 4'h7;
  localparam logic [3:0] OFS_AUX     = 4'h8;

  // ****************************************************************
  // reset values and implemented bit masks
  // ****************************************************************
  localparam logic [7:0] PIN_PRI_RST  = 8'h91;
  localparam logic [7:0] PIN_PRI_MASK = 8'hf3;
  localparam logic [7:0] PIN_SEC_RST  = 8'h11;
  localparam logic [7:0] PIN_SEC_MASK = 8'h33;
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int C0_PAUSE   = 7;
  localparam int C0_CLK_LSB = 4;
  localparam int C0_RUN     = 3;
  localparam int C0_PER_LSB = 0;
  localparam int C1_MODE_LSB = 6;
  localparam int C1_IO_LSB  = 4;
  localparam int C1_OC      = 3;
  localparam int C1_POL     = 2;
  localparam int C1_DPX     = 1;
  localparam int C1_CCLR    = 0;
  localparam int AUX_INV    = 0;
  localparam int PRI_T0P0   = 0;
  localparam int PRI_T0P1   = 1;

  // ****************************************************************
  // clock select codes and prescaler masks
  // ****************************************************************
  localparam logic [2:0] CLK_SYS4  = 3'h0;
  localparam logic [2:0] CLK_SYS   = 3'h1;
  localparam logic [2:0] CLK_H16   = 3'h2;
  localparam logic [2:0] CLK_H64   = 3'h3;
  localparam logic [2:0] CLK_TBC   = 3'h4;
  localparam logic [2:0] CLK_NONE  = 3'h5;
  localparam logic [2:0] CLK_EXT_R = 3'h6;
  localparam logic [2:0] CLK_EXT_F = 3'h7;
  localparam logic [5:0] PRE_MASK4  = 6'h03;
  localparam logic [5:0] PRE_MASK16 = 6'h0f;
  localparam logic [5:0] PRE_MASK64 = 6'h3f;

  // ****************************************************************
  // mode and output action codes
  // ****************************************************************
  localparam logic [1:0] MODE_CODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CODE_PWM = 2'h2;
  localparam logic [1:0] MODE_CODE_TMR = 2'h3;
  localparam logic [1:0] IO_NONE   = 2'h0;
  localparam logic [1:0] IO_LOW    = 2'h1;
  localparam logic [1:0] IO_HIGH   = 2'h2;
  localparam logic [1:0] IO_TOGGLE = 2'h3;
  localparam logic [2:0] PERIOD_FULL = 3'h0;

  typedef enum logic [2:0]
  {
    MODE_CMP = 3'b001,
    MODE_PWM = 3'b010,
    MODE_TMR = 3'b100
  } mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } regReq_t;

  typedef struct packed {
    logic [7:0] primary;
    logic [7:0] secondary;
  } pinSel_t;

endpackage
`default_nettype wire

// ---- compact_timer_pins.sv ----
// far-side model: shared pin functions, pads and timer clock pins
`timescale 1ns/100ps
`default_nettype none
module compact_timer_pins
(
  // clock
  input  wire logic       clk,
  // timer pins
  input  wire logic [1:0] pinOut,
  input  wire logic [1:0] pinOe,
  output logic [1:0]      padLevel,
  // shared functions
  output logic [1:0]      sharedOut,
  output logic [1:0]      sharedOe,
  // clock sources
  output logic            tbcTick,
  output logic            extClkPin
);
  logic [2:0] tbcDiv;

  // ****************************************************************
  // pads: released pins sit at the pull-up level
  // ****************************************************************
  assign padLevel = (pinOe & pinOut) | ~pinOe;
  assign tbcTick  = (tbcDiv == 3'h7);

  initial
  begin
    sharedOut = 2'h0;
    sharedOe  = 2'h0;
    extClkPin = 1'b0;
    tbcDiv    = 3'h0;
  end

  always @(posedge clk)
    tbcDiv <= tbcDiv + 3'h1;

  // ****************************************************************
  // shared function drive and external clock edges
  // ****************************************************************
  task automatic setShared(input logic [1:0] o, input logic [1:0] e);
    @(posedge clk);
    sharedOut <= o;
    sharedOe  <= e;
  endtask

  task automatic extEdges(input int n);
    repeat (n)
    begin
      @(posedge clk);
      extClkPin <= 1'b1;
      repeat (2) @(posedge clk);
      extClkPin <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ---- test_compact_timer.sv ----
// self-checking bench for the compact timer
`timescale 1ns/100ps
`default_nettype none
module test_compact_timer;
  import compact_timer_pkg::*;
  logic       clk;
  logic       rst;
  regReq_t    req;
  logic [7:0] rdData;
  logic       tbcTick;
  logic       extClkPin;
  logic [1:0] sharedOut;
  logic [1:0] sharedOe;
  logic [1:0] pinOut;
  logic [1:0] pinOe;
  logic [1:0] padLevel;
  pinSel_t    pinSel;
  logic       irqA;
  logic       irqP;
  int         errors;
  int         n_checks;
  int         cyc;
  int         nA;
  int         nP;
  int         lastA;
  int         lastP;
  int         perA;
  int         perP;

  compact_timer #(.CNT_W(10)) i_dut
  (
    .clk(clk), .rst(rst), .req(req), .rdData(rdData),
    .tbcTick(tbcTick), .extClkPin(extClkPin),
    .sharedOut(sharedOut), .sharedOe(sharedOe),
    .pinOut(pinOut), .pinOe(pinOe), .pinSel(pinSel),
    .irqA(irqA), .irqP(irqP)
  );

  compact_timer_pins i_pins
  (
    .clk(clk), .pinOut(pinOut), .pinOe(pinOe), .padLevel(padLevel),
    .sharedOut(sharedOut), .sharedOe(sharedOe),
    .tbcTick(tbcTick), .extClkPin(extClkPin)
  );

  // ****************************************************************
  // request pulse counting and spacing
  // ****************************************************************
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (irqA === 1'b1)
    begin
      nA    <= nA + 1;
      perA  <= cyc - lastA;
      lastA <= cyc;
    end
    if (irqP === 1'b1)
    begin
      nP    <= nP + 1;
      perP  <= cyc - lastP;
      lastP <= cyc;
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [9:0] seen,
                       input logic [9:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic wrPair(input logic [7:0] lo, input logic [7:0] hi);
    @(posedge clk);
    req <= '{addr: OFS_CMPA_LO, wdata: lo, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '{addr: OFS_CMPA_HI, wdata: hi, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [9:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    d = {2'h0, rdData};
  endtask

  task automatic rdCnt(output logic [9:0] v);
    logic [9:0] h;
    logic [9:0] l;
    rd(OFS_CNT_HI, h);
    rd(OFS_CNT_LO, l);
    check("counter high unused bits", {2'h0, h[9:2]}, 10'h000);
    v = {h[1:0], l[7:0]};
  endtask

  task automatic waitIrq(input bit onA, input int target, input int bound);
    int k;
    for (k = 0; k < bound; k++)
    begin
      @(posedge clk);
      #1;
      if ((onA ? nA : nP) >= target)
        break;
    end
    if (k == bound)
    begin
      errors++;
      $display("[ERR] request count expected %0d seen %0d", target,
               onA ? nA : nP);
      summarize();
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic testReset();
    logic [9:0] d;
    rd(OFS_PIN_PRI, d);
    check("primary reset", d, 10'h091);
    rd(OFS_PIN_SEC, d);
    check("secondary reset", d, 10'h011);
    rd(OFS_CMPA_LO, d);
    check("buffer reset", d, 10'h000);
    rd(OFS_CTRL0, d);
    check("control reset", d, 10'h000);
    rdCnt(d);
    check("counter reset", d, 10'h000);
    $display("done reset values");
  endtask

  task automatic testPinRegs();
    logic [9:0] d;
    wr(OFS_PIN_PRI, 8'hff);
    rd(OFS_PIN_PRI, d);
    check("primary mask", d, 10'h0f3);
    check("primary port", {2'h0, pinSel.primary}, 10'h0f3);
    wr(OFS_PIN_SEC, 8'hff);
    rd(OFS_PIN_SEC, d);
    check("secondary mask", d, 10'h033);
    check("secondary port", {2'h0, pinSel.secondary}, 10'h033);
    wr(OFS_PIN_SEC, 8'h22);
    rd(OFS_PIN_SEC, d);
    check("secondary pin1 bits", d, 10'h022);
    wr(OFS_PIN_PRI, 8'h00);
    rd(OFS_PIN_PRI, d);
    check("primary cleared", d, 10'h000);
    wr(4'h9, 8'hff);
    rd(4'h9, d);
    check("unmapped read", d, 10'h000);
    wr(OFS_PIN_PRI, 8'h91);
    wr(OFS_PIN_SEC, 8'h11);
    $display("done pin registers");
  endtask

  task automatic testBuffer();
    logic [9:0] d;
    wr(OFS_CMPA_LO, 8'h5a);
    rd(OFS_CMPA_HI, d);
    check("compare high before", d, 10'h000);
    rd(OFS_CMPA_LO, d);
    check("live low untouched", d, 10'h000);
    wrPair(8'h5a, 8'hff);
    rd(OFS_CMPA_HI, d);
    check("compare high bits", d, 10'h003);
    rd(OFS_CMPA_LO, d);
    check("compare low copied", d, 10'h05a);
    wr(OFS_CMPA_LO, 8'h33);
    rd(OFS_CMPA_LO, d);
    check("low read from buffer", d, 10'h033);
    rd(OFS_CMPA_HI, d);
    rd(OFS_CMPA_LO, d);
    check("low only via high", d, 10'h05a);
    $display("done holding buffer");
  endtask

  task automatic testPeriod();
    int base;
    wr(OFS_CTRL1, 8'h00);
    base = nP;
    wr(OFS_CTRL0, 8'h19);
    waitIrq(1'b0, base + 2, 400);
    check("period 1 spacing", 10'(perP), 10'd128);
    wr(OFS_CTRL0, 8'h00);
    base = nP;
    wr(OFS_CTRL0, 8'h18);
    waitIrq(1'b0, base + 2, 2200);
    check("overflow spacing", 10'(perP == 1024), 10'h001);
    wr(OFS_CTRL0, 8'h00);
    $display("done period comparator");
  endtask

  task automatic testClocks();
    logic [2:0] sel [4];
    int         per [4];
    int         base;
    sel = '{CLK_SYS4, CLK_H16, CLK_H64, CLK_TBC};
    per = '{512, 2048, 8192, 1024};
    wr(OFS_CTRL1, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      base = nP;
      wr(OFS_CTRL0, {1'b0, sel[i], 4'h9});
      waitIrq(1'b0, base + 2, 2 * per[i] + 200);
      check("source spacing", 10'(perP == per[i]), 10'h001);
      wr(OFS_CTRL0, 8'h00);
    end
    $display("done clock sources");
  endtask

  task automatic testCompare();
    int base;
    int pBase;
    wr(OFS_CMPA_LO, 8'h01);
    wr(OFS_CMPA_HI, 8'h02);
    wr(OFS_CTRL1, 8'h01);
    base  = nA;
    pBase = nP;
    wr(OFS_CTRL0, 8'h18);
    waitIrq(1'b1, base + 2, 1300);
    check("compare A spacing", 10'(perA), 10'd513);
    check("no overflow", 10'(nP - pBase), 10'h000);
    wr(OFS_CTRL0, 8'h00);
    $display("done compare A");
  endtask

  task automatic testCounterHold();
    logic [9:0] v1;
    logic [9:0] v2;
    wr(OFS_CTRL1, 8'h00);
    wr(OFS_CTRL0, 8'h19);
    repeat (50) @(posedge clk);
    wr(OFS_CTRL0, 8'h00);
    rdCnt(v1);
    check("counter moved", 10'(v1 != 10'h000), 10'h001);
    wr(OFS_CNT_LO, 8'hff);
    wr(OFS_CNT_HI, 8'h03);
    rdCnt(v2);
    check("counter not loadable", v2, v1);
    wr(OFS_CTRL0, 8'h58);
    repeat (10) @(posedge clk);
    rdCnt(v2);
    check("run rise clears", v2, 10'h000);
    wr(OFS_CTRL0, 8'h18);
    repeat (20) @(posedge clk);
    wr(OFS_CTRL0, 8'h98);
    rdCnt(v1);
    repeat (10) @(posedge clk);
    rdCnt(v2);
    check("pause holds count", v2, v1);
    wr(OFS_CTRL0, 8'h00);
    $display("done counter clear");
  endtask

  task automatic testExtClock();
    int base;
    wr(OFS_CMPA_LO, 8'h04);
    wr(OFS_CMPA_HI, 8'h00);
    wr(OFS_CTRL1, 8'h31);
    base = nA;
    wr(OFS_CTRL0, 8'h68);
    i_pins.extEdges(3);
    repeat (6) @(posedge clk);
    check("three pin edges", 10'(nA - base), 10'h000);
    check("level before match", 10'(padLevel[0]), 10'h000);
    i_pins.extEdges(1);
    repeat (6) @(posedge clk);
    check("fourth pin edge", 10'(nA - base), 10'h001);
    check("toggle on match", 10'(padLevel[0]), 10'h001);
    wr(OFS_CTRL0, 8'h78);
    i_pins.extEdges(4);
    repeat (6) @(posedge clk);
    check("falling pin edges", 10'(nA - base), 10'h002);
    wr(OFS_CTRL0, 8'h00);
    $display("done pin clock");
  endtask

  task automatic testPins();
    logic [1:0] codes [3];
    logic       expOe [3];
    codes = '{MODE_CODE_CMP, MODE_CODE_PWM, MODE_CODE_TMR};
    expOe = '{1'b1, 1'b1, 1'b0};
    i_pins.setShared(2'b10, 2'b11);
    repeat (3) @(posedge clk);
    check("released pin high", 10'(padLevel[1]), 10'h001);
    i_pins.setShared(2'b00, 2'b11);
    repeat (3) @(posedge clk);
    check("released pin low", 10'(padLevel[1]), 10'h000);
    wr(OFS_CTRL1, 8'h08);
    wr(OFS_CTRL0, 8'h58);
    repeat (3) @(posedge clk);
    check("timer pin level", 10'(padLevel[0]), 10'h001);
    wr(OFS_PIN_PRI, 8'h93);
    repeat (3) @(posedge clk);
    check("second pin same", 10'(padLevel[1]), 10'h001);
    wr(OFS_AUX, 8'h01);
    repeat (3) @(posedge clk);
    check("second pin inverse", 10'(padLevel[1]), 10'h000);
    wr(OFS_AUX, 8'h00);
    wr(OFS_PIN_PRI, 8'h90);
    i_pins.setShared(2'b00, 2'b01);
    repeat (3) @(posedge clk);
    check("pin0 released", 10'(padLevel), 10'h002);
    check("pin1 released oe", 10'(pinOe), 10'h001);
    wr(OFS_PIN_PRI, 8'h91);
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_CTRL0, 8'h00);
      wr(OFS_CTRL1, {codes[i], 6'h08});
      repeat (3) @(posedge clk);
      check("mode pin enable", 10'(pinOe[0]), 10'(expOe[i]));
    end
    wr(OFS_CTRL1, 8'h9c);
    repeat (3) @(posedge clk);
    check("pwm forced level", 10'(padLevel[0]), 10'h000);
    wr(OFS_CTRL1, 8'h00);
    $display("done pins and modes");
  endtask

  // ****************************************************************
  // clock, reset and main sequence
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    rst = 1'b1;
    req = '0;
    errors = 0;
    n_checks = 0;
    cyc = 0;
    nA = 0;
    nP = 0;
    lastA = 0;
    lastP = 0;
    perA = 0;
    perP = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    testReset();
    testPinRegs();
    testBuffer();
    testPeriod();
    testClocks();
    testCompare();
    testCounterHold();
    testExtClock();
    testPins();
    summarize();
  end
endmodule
`default_nettype wire
